// ---- rxsp_top.sv ----
// Status pins, strap capture, run control and identity registers
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module rxsp_top #(
   parameter logic [3:0] PART_ID = rxsp_pkg::PART_ID_DEF, // Arbitrary value
   parameter logic [3:0] REV_ID = rxsp_pkg::REV_ID_DEF     // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Receiver inputs and passthrough
   input wire logic [3:0] receiver_input_i,
   input wire logic [1:0] tx_route_select_i,
   output logic passthrough_out_o,
   output logic passthrough_oe_n_o,
   input wire logic passthrough_pin_i,
   // Decoder events (same clock)
   input wire logic z_preamble_i,
   input wire logic frame_clock_i,
   input wire logic cs_bit_i,
   input wire logic user_bit_i,
   input wire logic validity_err_i,
   input wire logic receive_err_i,
   input wire logic non_pcm_i,
   input wire logic [17:0] sample_rate_hz_i,
   input wire logic pll_locked_i,
   // Strap pins: inputs during reset, drivers after (aux output two and serial data out stay inputs)
   input wire logic error_pin_i,
   output logic error_out_o,
   output logic error_oe_n_o,
   input wire logic nonpcm_pin_i,
   output logic nonpcm_out_o,
   output logic nonpcm_oe_n_o,
   input wire logic high_rate_pin_i,
   output logic high_rate_flag_o,
   output logic high_rate_oe_n_o,
   input wire logic block_start_pin_i,
   output logic block_start_out_o,
   output logic block_start_oe_n_o,
   input wire logic cs_pin_i,
   output logic channel_status_out_o,
   output logic cs_oe_n_o,
   input wire logic user_pin_i,
   output logic user_bit_out_o,
   output logic user_oe_n_o,
   input wire logic aux_output_two_pin_i,
   input wire logic serial_data_out_pin_i,
   // Mode results
   output logic hardware_mode_o,
   output logic phase_detector_select_o,
   output logic emphasis_match_o,
   output logic port_master_o,
   output logic [1:0] format_select_o,
   output logic recovered_master_clock_128x_o,
   output logic i2c_addr_bit_o,
   output logic low_power_o,
   output logic audio_enable_o
);
   // ----------------------------------------------------------------
   // Strap pin synchronisers (three stages, last two must agree)
   // ----------------------------------------------------------------
   localparam int NSTRAP = 9;
   logic [NSTRAP-1:0] pin_raw;
   logic [NSTRAP-1:0] sync1_r, sync2_r, sync3_r; // Pin pipeline
   logic [NSTRAP-1:0] pin_stable_r;              // Filtered level
   assign pin_raw = {serial_data_out_pin_i, aux_output_two_pin_i, user_pin_i,
                     cs_pin_i, block_start_pin_i, high_rate_pin_i,
                     nonpcm_pin_i, error_pin_i, passthrough_pin_i};
   // Pipeline the pins; sync1 only feeds sync2
   always_ff @(posedge clk_i) begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
   end
   // Accept a change once stages two and three agree
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NSTRAP; i++) begin
         if (sync2_r[i] == sync3_r[i]) begin
            pin_stable_r[i] <= sync3_r[i];
         end
      end
   end
   // ----------------------------------------------------------------
   // Strap capture at reset exit
   // ----------------------------------------------------------------
   logic in_reset_r;                 // High while reset was held
   logic [NSTRAP-1:0] strap_r;       // Held strap levels
   // Flag that the previous edge was in reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_reset_r <= 1'b1;
      end else begin
         in_reset_r <= 1'b0;
      end
   end
   // Catch straps on first clock after release, then freeze
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_r <= '0;
      end else if (in_reset_r) begin
         strap_r <= pin_stable_r;
      end
   end
   // Pins act as inputs during reset and the capture edge
   logic drive_en;
   assign drive_en = !rst_i && !in_reset_r;
   // Decode straps into modes
   assign phase_detector_select_o = strap_r[0];
   assign format_select_o = {strap_r[2], strap_r[5]};
   assign emphasis_match_o = strap_r[3];
   assign port_master_o = strap_r[4];
   assign recovered_master_clock_128x_o = strap_r[6];
   assign i2c_addr_bit_o = strap_r[7];
   assign hardware_mode_o = !strap_r[8];
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   logic run_r;       // Software run bit
   logic running;     // Device is out of low power
   logic audio_en_r;  // Outputs released after lock
   logic wr_hit;
   assign wr_hit = avs_write_i && !avs_waitrequest_o;
   // Run bit, cleared by reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
      end else if (wr_hit && avs_address_i == rxsp_pkg::REG_CTRL) begin
         run_r <= avs_writedata_i[rxsp_pkg::CTRL_RUN_BIT];
      end
   end
   // Hardware mode runs on its own; software waits for run
   assign running = drive_en && (hardware_mode_o || run_r);
   assign low_power_o = !running;
   // Enable audio only after the loop has settled
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         audio_en_r <= 1'b0;
      end else if (pll_locked_i) begin
         audio_en_r <= 1'b1;
      end
   end
   assign audio_enable_o = audio_en_r;
   // ----------------------------------------------------------------
   // Passthrough
   // ----------------------------------------------------------------
   // Plain combinational mux: no retiming, so the edges are unjittered
   assign passthrough_out_o = receiver_input_i[tx_route_select_i];
   assign passthrough_oe_n_o = !drive_en;
   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   logic err_r, nonpcm_r, rate_r;
   // Status registers, muted while not running
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         err_r <= 1'b0;
         nonpcm_r <= 1'b0;
         rate_r <= 1'b0;
      end else begin
         err_r <= strap_r[1] ? receive_err_i : validity_err_i;
         nonpcm_r <= non_pcm_i;
         // Band between thresholds holds the last value
         if (sample_rate_hz_i <= 18'(rxsp_pkg::RATE_LOW_HZ)) begin
            rate_r <= 1'b0;
         end else if (sample_rate_hz_i >= 18'(rxsp_pkg::RATE_HIGH_HZ)) begin
            rate_r <= 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // Block start pulse, counted in frames
   // ----------------------------------------------------------------
   logic frame_d_r;          // Previous frame clock
   logic frame_start;        // Rising frame clock
   logic [7:0] frame_cnt_r;  // Frames since Z
   logic blk_r;
   logic blk_active_r;
   assign frame_start = frame_clock_i && !frame_d_r;
   // Frame clock edge detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_d_r <= 1'b0;
      end else begin
         frame_d_r <= frame_clock_i;
      end
   end
   // Count frames after Z preamble and shape the pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         frame_cnt_r <= 8'h00;
         blk_active_r <= 1'b0;
         blk_r <= 1'b0;
      end else if (z_preamble_i) begin
         frame_cnt_r <= 8'h00;
         blk_active_r <= 1'b1;
         blk_r <= 1'b0;
      end else if (frame_start && blk_active_r) begin
         frame_cnt_r <= frame_cnt_r + 8'h01;
         if (frame_cnt_r + 8'h01 == rxsp_pkg::BLK_RISE_FRAMES) begin
            blk_r <= 1'b1;
         end else if (frame_cnt_r + 8'h01 ==
                      rxsp_pkg::BLK_RISE_FRAMES + rxsp_pkg::BLK_HIGH_FRAMES) begin
            blk_r <= 1'b0;
            blk_active_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Channel status and user bits, updated on both frame edges
   // ----------------------------------------------------------------
   logic cs_r, ub_r;
   // Any frame clock change shifts the next bit out
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         cs_r <= 1'b0;
         ub_r <= 1'b0;
      end else if (frame_clock_i != frame_d_r) begin
         cs_r <= cs_bit_i;
         ub_r <= user_bit_i;
      end
   end
   // Pin outputs with enables low while driving
   assign error_out_o = err_r;
   assign nonpcm_out_o = nonpcm_r;
   assign high_rate_flag_o = rate_r;
   assign block_start_out_o = blk_r;
   assign channel_status_out_o = cs_r;
   assign user_bit_out_o = ub_r;
   assign error_oe_n_o = !drive_en;
   assign nonpcm_oe_n_o = !drive_en;
   assign high_rate_oe_n_o = !drive_en;
   assign block_start_oe_n_o = !drive_en;
   assign cs_oe_n_o = !drive_en;
   assign user_oe_n_o = !drive_en;
   // ----------------------------------------------------------------
   // Avalon slave: one wait cycle per access
   // ----------------------------------------------------------------
   logic ack_r;
   // Waitrequest drops one cycle after a request appears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      end
   end
   assign avs_waitrequest_o = !ack_r;
   // Read mux; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && !ack_r) begin
         unique case (avs_address_i)
            rxsp_pkg::REG_CTRL: avs_readdata_o <= {31'h0, run_r};
            rxsp_pkg::REG_STRAPS: avs_readdata_o <= {23'h0, strap_r};
            rxsp_pkg::REG_STATUS: avs_readdata_o <= {26'h0, audio_en_r, blk_r,
                                          rate_r, nonpcm_r, err_r, low_power_o};
            rxsp_pkg::REG_IDENT: avs_readdata_o <= {24'h0, PART_ID, REV_ID};
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// ---- rxsp_pkg.sv ----
// Package with constants for the receiver status pins and start-up block
// Summary of operation
// - Route select picks one input for passthrough
// - Passthrough is unretimed, full swing copy
// - Passthrough strap sets phase detector select
// - Error strap picks validity or receive error
// - Non-PCM pin low for PCM; strap hi
// - High rate flag: 0 at 48k or below, 1 at 88.1k and above
// - High rate strap enables emphasis match
// - Block start: high 16 frames, two after Z
// - Block start strap picks port master/slave
// - Channel status shifts on both frame edges
// - User bits shift on both frame edges
// - User strap picks master clock ratio
// - Low user strap 256x, high 128x
// - Reset holds low power, clears, mutes
// - Run bit written starts operation
// - Audio outputs wait for loop lock
// - Straps sampled at reset exit, then drive
// - Software mode straps: address bit, mode
// - Serial data strap low selects hardware mode
// - Readable 4-bit part identification code
// - Readable 4-bit revision code
package rxsp_pkg;
   // ----------------------------------------------------------------
   // Register map (word offsets on Avalon byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;      // Run bit only
   localparam logic [3:0] REG_STRAPS = 4'h4;    // Captured straps
   localparam logic [3:0] REG_STATUS = 4'h8;    // Live status
   localparam logic [3:0] REG_IDENT = 4'hC;     // Id and revision
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_RESET_VAL = 0;
   // ----------------------------------------------------------------
   // Frame timing of block start
   // ----------------------------------------------------------------
   localparam logic [7:0] BLK_RISE_FRAMES = 8'h02;   // Delay after Z
   localparam logic [7:0] BLK_HIGH_FRAMES = 8'h10;   // High for 16
   // Rate thresholds in Hz
   localparam int RATE_LOW_HZ = 48000;
   localparam int RATE_HIGH_HZ = 88100;
   // Synchroniser depth for pin inputs
   localparam int SYNC_DEPTH = 3;
   // Id codes: values are arbitrary
   localparam logic [3:0] PART_ID_DEF = 4'h5;
   localparam logic [3:0] REV_ID_DEF = 4'h1;
endpackage

// ---- rxsp_top_assertions.sv ----
// Concurrent checks on the status pin and start-up ports
`timescale 1ns/1ns
module rxsp_top_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic [3:0] receiver_input_i,
   input wire logic [1:0] tx_route_select_i,
   input wire logic passthrough_out_o,
   input wire logic frame_clock_i,
   input wire logic channel_status_out_o,
   input wire logic user_bit_out_o,
   input wire logic [17:0] sample_rate_hz_i,
   input wire logic high_rate_flag_o,
   input wire logic error_oe_n_o,
   input wire logic user_oe_n_o,
   input wire logic hardware_mode_o,
   input wire logic [1:0] format_select_o,
   input wire logic low_power_o,
   input wire logic audio_enable_o,
   input wire logic pll_locked_i
);
   // Edges since reset release; saturates so it never wraps
   logic [1:0] age_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_PASS_ROUTE: assert property (
      passthrough_out_o == receiver_input_i[tx_route_select_i]) else $error("route");
   AST_BUS_ANSWER: assert property (
      $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer");
   AST_DRIVE_ON: assert property (
      $fell(rst_i) |-> error_oe_n_o ##2 (!error_oe_n_o && !user_oe_n_o)) else $error("oe");
   AST_STRAP_HOLD: assert property (
      age_r == 2'h3 |-> $stable({hardware_mode_o, format_select_o})) else $error("strap");
   AST_RATE_LOW: assert property (
      (sample_rate_hz_i <= 18'h0BB80)[*4] |-> !high_rate_flag_o) else $error("rate low");
   AST_CS_EDGE: assert property (
      $changed(channel_status_out_o) |-> $past(frame_clock_i) != $past(frame_clock_i, 2))
      else $error("cs edge");
   AST_USER_EDGE: assert property (
      $changed(user_bit_out_o) |-> $past(frame_clock_i) != $past(frame_clock_i, 2))
      else $error("user edge");
   AST_RESET_MUTE: assert property (disable iff (1'b0)
      rst_i |=> low_power_o && !audio_enable_o && avs_waitrequest_o) else $error("mute");
   AST_AUDIO_LOCK: assert property (
      (!pll_locked_i)[*3] |-> !audio_enable_o) else $error("lock");
endmodule

// ---- rxsp_strap_model.sv ----
// Board strap resistors and pin resolution around the device
`timescale 1ns/1ns
module rxsp_strap_model (
   input wire logic [8:0] strap_i, // {serial_data_out,aux2,user,cs,blk,rate,nonpcm,err,tx}
   input wire logic [5:0] oe_n_i, // {user,cs,blk,rate,nonpcm,err}
   input wire logic [5:0] out_i,
   input wire logic pass_oe_n_i,
   input wire logic pass_out_i,
   output logic [8:0] pin_o
);
   // Resistor level shows only while the device driver is off
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_o[i+1] = oe_n_i[i] ? strap_i[i+1] : out_i[i];
      end
      pin_o[0] = pass_oe_n_i ? strap_i[0] : pass_out_i;
      pin_o[8:7] = strap_i[8:7];
   end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the status pin and start-up block
`timescale 1ns/1ns
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0, receiver_input_i = 4'h0;
   logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
   logic [1:0] tx_route_select_i = 2'h0, format_select_o;
   logic z_preamble_i = 1'b0, frame_clock_i = 1'b0, cs_bit_i = 1'b0, user_bit_i = 1'b0;
   logic validity_err_i = 1'b0, receive_err_i = 1'b0, non_pcm_i = 1'b0, pll_locked_i = 1'b0;
   logic [17:0] sample_rate_hz_i = 18'h0;
   logic passthrough_out_o, passthrough_oe_n_o, passthrough_pin_i, error_pin_i, error_out_o;
   logic error_oe_n_o, nonpcm_pin_i, nonpcm_out_o, nonpcm_oe_n_o, high_rate_pin_i;
   logic high_rate_flag_o, high_rate_oe_n_o, block_start_pin_i, block_start_out_o;
   logic block_start_oe_n_o, cs_pin_i, channel_status_out_o, cs_oe_n_o, user_pin_i;
   logic user_bit_out_o, user_oe_n_o, aux_output_two_pin_i, serial_data_out_pin_i;
   logic hardware_mode_o, phase_detector_select_o, emphasis_match_o, port_master_o;
   logic recovered_master_clock_128x_o, i2c_addr_bit_o, low_power_o, audio_enable_o;
   logic [8:0] straps = 9'h0; // Board strap levels
   logic [17:0] rates [4] = '{18'h07D00, 18'h0BB80, 18'h15824, 18'h2EE00};
   int fail_count = 0;
   int check_count = 0;
   // Id values are arbitrary
   rxsp_top #(.PART_ID(4'hA), .REV_ID(4'h3)) rxsp_top_inst (.*);
   rxsp_strap_model rxsp_strap_model_inst (
      .strap_i(straps),
      .oe_n_i({user_oe_n_o, cs_oe_n_o, block_start_oe_n_o, high_rate_oe_n_o, nonpcm_oe_n_o,
         error_oe_n_o}),
      .out_i({user_bit_out_o, channel_status_out_o, block_start_out_o, high_rate_flag_o,
         nonpcm_out_o, error_out_o}),
      .pass_oe_n_i(passthrough_oe_n_o),
      .pass_out_i(passthrough_out_o),
      .pin_o({serial_data_out_pin_i, aux_output_two_pin_i, user_pin_i, cs_pin_i,
         block_start_pin_i, high_rate_pin_i, nonpcm_pin_i, error_pin_i, passthrough_pin_i}));
   always #5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // Avalon cycle held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_writedata_i <= d;
      // Sampled at each rising edge before that edge's updates land
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 100);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (n >= 100) fail_count++;
   endtask
   task automatic test_done;
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Reset with given straps, then check the captured modes
   task automatic reset_with(input logic [8:0] s);
      @(posedge clk_i);
      straps <= s;
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(low_power_o, 1'b1);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk({hardware_mode_o, i2c_addr_bit_o, recovered_master_clock_128x_o, format_select_o, port_master_o,
         emphasis_match_o, phase_detector_select_o}, {!s[8], s[7:6], s[2], s[5], s[4:3], s[0]});
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, {23'h0, s});
   endtask
   task automatic status(input logic rx_sel);
      for (int e = 0; e < 4; e++) begin
         @(posedge clk_i);
         {receive_err_i, validity_err_i} <= e[1:0];
         non_pcm_i <= e[0];
         repeat (5) @(posedge clk_i);
         chk(error_out_o, rx_sel ? e[1] : e[0]);
         chk(nonpcm_out_o, e[0]);
      end
   endtask
   initial begin
      reset_with(9'h1AA);
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, 32'hA3);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      chk(low_power_o, 1'b1);
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h1);
      chk(low_power_o, 1'b0);
      chk(audio_enable_o, 1'b0);
      pll_locked_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(audio_enable_o, 1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         tx_route_select_i <= i[1:0];
         receiver_input_i <= 4'h1 << i;
         @(negedge clk_i);
         chk(passthrough_out_o, 1'b1);
         @(posedge clk_i);
         receiver_input_i <= ~(4'h1 << i);
         @(negedge clk_i);
         chk(passthrough_out_o, 1'b0);
         @(posedge clk_i);
         sample_rate_hz_i <= rates[i];
         repeat (5) @(posedge clk_i);
         chk(high_rate_flag_o, i > 1);
      end
      status(1'b1);
      @(posedge clk_i);
      z_preamble_i <= 1'b1;
      @(posedge clk_i);
      z_preamble_i <= 1'b0;
      for (int k = 1; k <= 20; k++) begin
         repeat (3) @(posedge clk_i);
         frame_clock_i <= 1'b1;
         {cs_bit_i, user_bit_i} <= {k[0], !k[0]};
         repeat (3) @(posedge clk_i);
         chk(block_start_out_o, k >= 2 && k < 18);
         chk({channel_status_out_o, user_bit_out_o}, {k[0], !k[0]});
         frame_clock_i <= 1'b0;
         {cs_bit_i, user_bit_i} <= {!k[0], k[0]};
         repeat (3) @(posedge clk_i);
         chk({channel_status_out_o, user_bit_out_o}, {!k[0], k[0]});
      end
      reset_with(9'h055);
      chk(low_power_o, 1'b0);
      status(1'b0);
      test_done;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      test_done;
   end
endmodule
bind rxsp_top rxsp_top_assertions rxsp_top_assertions_inst (.*);
